// file: hdl/res_regs.sv
// rail enable, lockout level and sequencer step register bank
// Functional notes
// - protected registers change only through an authorised protected write
// - rail enable at 0x16 resets 0x00, bits 6..0 enable seven rails
// - switch one turns on only while power request pin is high
// - switch two turns on only while power request pin is high
// - buck converters enabled only while power request pin is high
// - rail enable bit 7 is read-only zero
// - lockout at 0x18 resets 0x03, two-bit field selects threshold level
// - lockout bits 7..3 read zero, bit 2 is plain read/write
// - a zero step field leaves the rail outside sequencer control
// - bits 7 and 3 of 0x19 read as zero
// - 0x1a holds buck three step 6..4, regulator one step 3..0
// - buck three step seven also maps to slot six
// - regulator one codes 8,9 uncontrolled, 10-13 reserved, 14 and 15 slots
`timescale 1ns/1ps
module res_regs
    import res_pkg::*;
#(
    parameter logic [7:0] STEPS_ONE_RESET = RST_STEPS_ONE,
    parameter logic [7:0] STEPS_TWO_RESET = RST_STEPS_TWO
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire res_bus_t bus_in,
    input wire logic power_request_pin_in,
    output res_rails_t rail_on_out,
    output logic [1:0] lockout_level_field_out,
    output res_slots_t rail_slot_out,
    output logic [DATA_W-1:0] rdata_out
);

    // ==========================================================
    // register storage
    logic [7:0] rail_enable;
    logic [7:0] lockout_threshold;
    logic [7:0] sequence_steps_one;
    logic [7:0] sequence_steps_two;
    logic [7:0] next_rail_enable;
    logic [7:0] next_lockout_threshold;
    logic [7:0] next_sequence_steps_one;
    logic [7:0] next_sequence_steps_two;
    logic do_wr;

    always_comb begin
        do_wr = bus_in.wr && bus_in.wr_auth;
        next_rail_enable = rail_enable;
        next_lockout_threshold = lockout_threshold;
        next_sequence_steps_one = sequence_steps_one;
        next_sequence_steps_two = sequence_steps_two;
        if (do_wr) begin
            unique case (bus_in.addr)
                OFF_RAIL_ENABLE: begin
                    next_rail_enable = bus_in.wdata & MASK_RAIL_ENABLE;
                end
                OFF_LOCKOUT: begin
                    next_lockout_threshold = bus_in.wdata & MASK_LOCKOUT;
                end
                OFF_STEPS_ONE: begin
                    next_sequence_steps_one = bus_in.wdata & MASK_STEPS_ONE;
                end
                OFF_STEPS_TWO: begin
                    next_sequence_steps_two = bus_in.wdata & MASK_STEPS_TWO;
                end
                default: begin
                    next_rail_enable = rail_enable;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rail_enable <= RST_RAIL_ENABLE;
            lockout_threshold <= RST_LOCKOUT;
            sequence_steps_one <= STEPS_ONE_RESET & MASK_STEPS_ONE;
            sequence_steps_two <= STEPS_TWO_RESET & MASK_STEPS_TWO;
        end else if (clk_en_in) begin
            rail_enable <= next_rail_enable;
            lockout_threshold <= next_lockout_threshold;
            sequence_steps_one <= next_sequence_steps_one;
            sequence_steps_two <= next_sequence_steps_two;
        end
    end

    // ==========================================================
    // read data, valid one cycle after the read strobe
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                OFF_RAIL_ENABLE: next_rdata = rail_enable;
                OFF_LOCKOUT: next_rdata = lockout_threshold;
                OFF_STEPS_ONE: next_rdata = sequence_steps_one;
                OFF_STEPS_TWO: next_rdata = sequence_steps_two;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            rdata_out <= next_rdata;
        end
    end

    // ==========================================================
    // step field decode into sequence slots
    function automatic logic [3:0] slot3(input logic [2:0] code, input logic cap);
        logic [3:0] s;
        s = {1'b0, code};
        if (code == STEP3_OFF) begin
            s = SLOT_NONE;
        end else if (cap && code > STEP3_CAP) begin
            s = {1'b0, STEP3_CAP};
        end
        return s;
    endfunction

    function automatic logic [3:0] slot4(input logic [3:0] code);
        logic [3:0] s;
        s = SLOT_NONE;
        if (code <= STEP4_MAX_LOW) begin
            s = code;
        end else if (code == STEP4_SLOT14 || code == STEP4_SLOT15) begin
            s = code;
        end
        return s;
    endfunction

    // ==========================================================
    // rail gating and registered outputs
    localparam int RAIL_N = 7;
    localparam logic [RAIL_N-1:0] PIN_GATED = 7'h7c;
    logic [RAIL_N-1:0] next_rail_vec;
    res_rails_t next_rail_on;
    res_slots_t next_slot;
    logic [1:0] next_level;

    // switches and bucks follow the power request pin, regulators do not
    for (genvar g = 0; g < RAIL_N; g++) begin : g_rail
        assign next_rail_vec[g] = PIN_GATED[g]
            ? (rail_enable[g] && power_request_pin_in) : rail_enable[g];
    end

    always_comb begin
        next_rail_on = res_rails_t'(next_rail_vec);
        next_level = lockout_threshold[1:0];
        next_slot.buck_one = slot3(sequence_steps_one[STEP_HI_LSB +: 3], 1'b0);
        next_slot.buck_two = slot3(sequence_steps_one[STEP_LO_LSB +: 3], 1'b0);
        next_slot.buck_three = slot3(sequence_steps_two[STEP_HI_LSB +: 3], 1'b1);
        next_slot.regulator_one = slot4(sequence_steps_two[STEP_LO_LSB +: 4]);
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rail_on_out <= '0;
            lockout_level_field_out <= RST_LOCKOUT[1:0];
            rail_slot_out <= '0;
        end else if (clk_en_in) begin
            rail_on_out <= next_rail_on;
            lockout_level_field_out <= next_level;
            rail_slot_out <= next_slot;
        end
    end

endmodule

// file: hdl/res_pkg.sv
// package for the rail enable and sequence register bank
package res_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_RAIL_ENABLE = 8'h16;
    localparam logic [7:0] OFF_LOCKOUT = 8'h18;
    localparam logic [7:0] OFF_STEPS_ONE = 8'h19;
    localparam logic [7:0] OFF_STEPS_TWO = 8'h1a;
    localparam logic [7:0] RST_RAIL_ENABLE = 8'h00;
    localparam logic [7:0] RST_LOCKOUT = 8'h03;
    localparam logic [7:0] RST_STEPS_ONE = 8'h15;
    localparam logic [7:0] RST_STEPS_TWO = 8'h5f;
    localparam logic [7:0] MASK_RAIL_ENABLE = 8'h7f;
    localparam logic [7:0] MASK_LOCKOUT = 8'h07;
    localparam logic [7:0] MASK_STEPS_ONE = 8'h77;
    localparam logic [7:0] MASK_STEPS_TWO = 8'h7f;
    localparam int BIT_SW1 = 6;
    localparam int BIT_SW2 = 5;
    localparam int BIT_BUCK1 = 4;
    localparam int BIT_BUCK2 = 3;
    localparam int BIT_BUCK3 = 2;
    localparam int BIT_REG1 = 1;
    localparam int BIT_REG2 = 0;
    localparam int STEP_HI_LSB = 4;
    localparam int STEP_LO_LSB = 0;
    localparam logic [2:0] STEP3_OFF = 3'h0;
    localparam logic [2:0] STEP3_CAP = 3'h6;
    localparam logic [3:0] STEP4_OFF = 4'h0;
    localparam logic [3:0] STEP4_MAX_LOW = 4'h7;
    localparam logic [3:0] STEP4_SLOT14 = 4'he;
    localparam logic [3:0] STEP4_SLOT15 = 4'hf;
    localparam logic [3:0] SLOT_NONE = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic wr_auth;
    } res_bus_t;

    typedef struct packed {
        logic switch_one;
        logic switch_two;
        logic buck_one;
        logic buck_two;
        logic buck_three;
        logic regulator_one;
        logic regulator_two;
    } res_rails_t;

    typedef struct packed {
        logic [3:0] buck_one;
        logic [3:0] buck_two;
        logic [3:0] buck_three;
        logic [3:0] regulator_one;
    } res_slots_t;
endpackage

// file: testbench/res_regs_sva.sv
// assertion checker for the rail enable and sequence register bank
`timescale 1ns/1ps
module res_regs_sva
    import res_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire res_bus_t bus_in,
    input wire logic power_request_pin_in,
    input wire res_rails_t rail_on_out,
    input wire logic [1:0] lockout_level_field_out,
    input wire res_slots_t rail_slot_out,
    input wire logic [DATA_W-1:0] rdata_out
);
    // ====================
    // properties
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    AST_EN_RESV: assert property (clk_en_in && bus_in.rd && bus_in.addr == 8'h16 |=>
        !rdata_out[7]) else $error("rail enable bit 7 read set");
    AST_LOCK_RESV: assert property (clk_en_in && bus_in.rd && bus_in.addr == 8'h18 |=>
        rdata_out[7:3] == 5'h00) else $error("lockout reserved bits read set");
    AST_SEQUENCE_STEPS_ONE_RESV: assert property (clk_en_in && bus_in.rd && bus_in.addr == 8'h19 |=>
        !rdata_out[7] && !rdata_out[3]) else $error("step one reserved bits read set");
    AST_SEQUENCE_STEPS_TWO_RESV: assert property (clk_en_in && bus_in.rd && bus_in.addr == 8'h1a |=>
        !rdata_out[7]) else $error("step two bit 7 read set");
    AST_SW1_GATE: assert property (clk_en_in && !power_request_pin_in |=>
        !rail_on_out.switch_one) else $error("switch one on with pin low");
    AST_SW2_GATE: assert property (clk_en_in && !power_request_pin_in |=>
        !rail_on_out.switch_two) else $error("switch two on with pin low");
    AST_BUCK_GATE: assert property (clk_en_in && !power_request_pin_in |=>
        rail_on_out[4:2] == 3'h0) else $error("buck on with pin low");
    AST_LOCK_WR: assert property ((clk_en_in && bus_in.wr && bus_in.wr_auth
        && bus_in.addr == 8'h18) ##1 clk_en_in |=> lockout_level_field_out ==
        $past(bus_in.wdata[1:0], 2)) else $error("lockout level not taken from write");
    AST_NO_AUTH: assert property ((clk_en_in && bus_in.wr && !bus_in.wr_auth
        && bus_in.addr == 8'h18) ##1 clk_en_in |=> lockout_level_field_out ==
        $past(lockout_level_field_out)) else $error("lockout level changed by refused write");
    AST_FREEZE: assert property (!clk_en_in |=> $stable(rail_on_out) &&
        $stable(lockout_level_field_out) && $stable(rail_slot_out) && $stable(rdata_out))
        else $error("outputs moved while clock enable low");
endmodule
bind res_regs res_regs_sva i_sva (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .clk_en_in(clk_en_in), .bus_in(bus_in), .power_request_pin_in(power_request_pin_in),
    .rail_on_out(rail_on_out), .lockout_level_field_out(lockout_level_field_out),
    .rail_slot_out(rail_slot_out), .rdata_out(rdata_out));

// file: testbench/res_regs_test.sv
// self-checking bench for the rail enable and sequence register bank
`timescale 1ns/1ps
module res_regs_test
    import res_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic pin = 1'b0;
    res_bus_t bus = '0;
    res_rails_t rail_on;
    logic [1:0] level;
    res_slots_t slots;
    logic [7:0] rdata;
    logic [3:0] c;
    logic clk_en = 1'b1;
    int errors = 0;
    int check_count = 0;
    logic [7:0] offs [4] = '{8'h16, 8'h18, 8'h19, 8'h1a};
    logic [7:0] masks [4] = '{8'h7f, 8'h07, 8'h77, 8'h7f};
    always #5 core_clk_in = ~core_clk_in;
    res_regs i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
        .bus_in(bus), .power_request_pin_in(pin), .rail_on_out(rail_on),
        .lockout_level_field_out(level), .rail_slot_out(slots), .rdata_out(rdata));
    // ====================
    // tasks
    task stop_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge core_clk_in);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d, input logic au);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, wr_auth: au};
        @(posedge core_clk_in);
        bus <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, wr_auth: 1'b0};
        @(posedge core_clk_in);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask
    // ====================
    // tests
    initial begin
        #20000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        tick();
        chk(level, 16'h0003);
        chk(slots, 16'h155f);
        rd(8'h16, 8'h00);
        rd(8'h18, 8'h03);
        rd(8'h19, 8'h15);
        rd(8'h1a, 8'h5f);
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 8'hff, 1'b1);
            rd(offs[i], masks[i]);
        end
        wr(8'h16, 8'h00, 1'b0);
        rd(8'h16, 8'h7f);
        wr(8'h18, 8'h00, 1'b0);
        rd(8'h18, 8'h07);
        rd(8'h17, 8'h00);
        chk(rail_on, 16'h0003);
        @(posedge core_clk_in);
        pin <= 1'b1;
        tick();
        tick();
        chk(rail_on, 16'h007f);
        wr(8'h16, 8'h2a, 1'b1);
        tick();
        chk(rail_on, 16'h002a);
        @(posedge core_clk_in);
        pin <= 1'b0;
        tick();
        tick();
        chk(rail_on, 16'h0002);
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            wr(8'h19, {1'b0, c[2:0], 1'b0, c[2:0]}, 1'b1);
            wr(8'h1a, {1'b0, c[2:0], c}, 1'b1);
            wr(8'h18, {5'h00, c[2:0]}, 1'b1);
            tick();
            chk(slots, {1'b0, c[2:0], 1'b0, c[2:0], 1'b0, ((c[2:0] == 3'h7) ? 3'h6 : c[2:0]),
                ((c > 4'h7 && c < 4'he) ? 4'h0 : c)});
            chk(level, {14'h0000, c[1:0]});
            rd(8'h18, {5'h00, c[2:0]});
        end
        // clock enable low freezes writes and outputs
        @(posedge core_clk_in);
        clk_en <= 1'b0;
        pin <= 1'b1;
        wr(8'h18, 8'h01, 1'b1);
        tick();
        chk(level, 16'h0003);
        chk(rail_on, 16'h0002);
        @(posedge core_clk_in);
        clk_en <= 1'b1;
        rd(8'h18, 8'h07);
        chk(rail_on, 16'h002a);
        // reset in mid-run restores the reset values
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        @(posedge core_clk_in);
        rstn_in <= 1'b1;
        rd(8'h16, 8'h00);
        rd(8'h18, 8'h03);
        chk(rail_on, 16'h0000);
        chk(level, 16'h0003);
        stop_test();
    end
endmodule
